// >>> src/mdgcs_pkg.sv
// Package for the global configuration and status register bank
package mdgcs_pkg;

	// Register addresses, seven bits as carried in the address byte
	localparam logic [6:0] ADDR_GLOBAL_CONFIG_FLAGS = 7'h00;
	localparam logic [6:0] ADDR_GLOBAL_STATUS_FLAGS = 7'h01;
	localparam logic [6:0] ADDR_INPUT_PINS = 7'h04;
	localparam logic [6:0] ADDR_OTP_PROGRAM_TRIGGER = 7'h06;
	localparam logic [6:0] ADDR_COIL_DIRECT = 7'h2D;

	// Serial datagram layout: write flag, address, then 32 data bits
	localparam int FRAME_BITS = 40;
	localparam int WR_FLAG_POS = 39;
	localparam int ADDR_LSB = 32;
	localparam logic [5:0] FRAME_LEN = 6'h28;
	localparam logic [5:0] CNT_MAX = 6'h3F;

	// Configuration flag positions and reset value
	localparam int GLOBAL_CONFIG_FLAGS_W = 18;
	localparam int CFG_SMALL_HYST = 14;
	localparam int CFG_STOP_EN = 15;
	localparam int CFG_DIRECT = 16;
	localparam int CFG_TEST = 17;
	localparam logic [GLOBAL_CONFIG_FLAGS_W-1:0] GLOBAL_CONFIG_FLAGS_RST = 18'h00000;

	// Status flag positions and reset value (reset flag set)
	localparam int GLOBAL_STATUS_FLAGS_W = 3;
	localparam int ST_RESET = 0;
	localparam int ST_DRV_ERR = 1;
	localparam int ST_PUMP_UV = 2;
	localparam logic [GLOBAL_STATUS_FLAGS_W-1:0] GLOBAL_STATUS_FLAGS_RST = 3'h1;

	// Direct coil current register layout and reset value
	localparam int COIL_W = 9;
	localparam int COIL_A_LSB = 0;
	localparam int COIL_B_LSB = 16;
	localparam logic [31:0] COIL_CURRENT_DIRECT_REG_RST = 32'h00000000;
	localparam logic [31:0] COIL_CURRENT_DIRECT_REG_MASK = 32'h01FF01FF;

	// Input snapshot layout
	localparam int IN_PINS_W = 6;
	localparam int IN_FIXED_ONE = 6;
	localparam int VERSION_LSB = 24;

	// Write-only programming trigger width
	localparam int OTP_W = 16;
	localparam logic [OTP_W-1:0] OTP_RST = 16'h0000;

	// Hysteresis divisors as right shifts: 1/16 and 1/32
	localparam int HYST_SHIFT_WIDE = 4;
	localparam int HYST_SHIFT_NARROW = 5;
	localparam int PERIOD_W = 20;

	typedef enum logic {
		SPI_IDLE,
		SPI_SHIFT
	} mdgcs_spi_e;

	// Snapshot pins, packed so that step lands in bit 0
	typedef struct packed {
		logic diag_output_pin;
		logic driver_disable_pin;
		logic speed_mode_input_pin;
		logic speed_mode_enable_pin;
		logic dir;
		logic step;
	} mdgcs_pins_s;

	// Serial interface pins toward the host
	typedef struct packed {
		logic sck;
		logic csn;
		logic sdi;
	} mdgcs_spi_s;

	// All state of the bank
	typedef struct packed {
		mdgcs_spi_e spi_state;
		mdgcs_spi_s spi_m;
		mdgcs_spi_s spi_s;
		logic sck_d;
		mdgcs_pins_s pins_m;
		mdgcs_pins_s pins_s;
		logic uv_m;
		logic uv_s;
		logic [FRAME_BITS-1:0] in_shift;
		logic [FRAME_BITS-1:0] out_shift;
		logic [5:0] bit_cnt;
		logic [31:0] rdata;
		logic [GLOBAL_CONFIG_FLAGS_W-1:0] global_config_flags;
		logic [GLOBAL_STATUS_FLAGS_W-1:0] global_status_flags;
		logic [31:0] coil_current_direct_reg;
		logic otp_stb;
		logic [OTP_W-1:0] otp_data;
		logic [COIL_W-1:0] coil_a;
		logic [COIL_W-1:0] coil_b;
		logic fast;
		logic halt;
		logic drv_enable;
	} mdgcs_state_s;

endpackage

// >>> src/mdgcs_top.sv
// Global configuration and status register bank behind the serial port
`timescale 1ns/100ps

module mdgcs_top import mdgcs_pkg::*; #(
	// Arbitrary neutral version code
	parameter logic [7:0] VERSION_CODE = 8'h5A
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Serial register port
	input wire logic sck,
	input wire logic csn,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	// Input pins shown in the snapshot
	input wire logic step,
	input wire logic dir,
	input wire logic speed_mode_enable_pin,
	input wire logic speed_mode_input_pin,
	input wire logic driver_disable_pin,
	input wire logic diag_output_pin_i,
	// Diagnostic pin drive in test mode
	output logic diag_output_pin_o,
	output logic diag_output_pin_oe,
	output logic analog_test_en,
	output logic [1:0] analog_test_sel,
	// Analog supervisor level from the charge pump
	input wire logic pump_undervolt_pin,
	// Protection events from the power stage logic
	input wire logic overtemp_shutdown,
	input wire logic short_shutdown,
	input wire logic temp_above_limit,
	// Current setting and sequencer values from the motor core
	input wire logic [4:0] standstill_current_level,
	input wire logic [COIL_W-1:0] seq_coil_a,
	input wire logic [COIL_W-1:0] seq_coil_b,
	// Step-frequency comparison operands
	input wire logic [PERIOD_W-1:0] step_period,
	input wire logic [PERIOD_W-1:0] period_threshold,
	// Outputs to the motor core
	output logic step_faster_than_thr,
	output logic sequencer_halt,
	output logic direct_mode_active,
	output logic scale_by_standstill,
	output logic velocity_reg_disable,
	output logic [COIL_W-1:0] coil_a_current,
	output logic [COIL_W-1:0] coil_b_current,
	output logic driver_enable,
	// One-time memory programming request
	output logic otp_program_trigger_stb,
	output logic [OTP_W-1:0] otp_program_trigger_data
);

	mdgcs_state_s st_r;
	mdgcs_state_s st_nxt;

	logic sck_rise;
	logic sck_fall;
	logic csn_fall;
	logic csn_rise;
	logic frame_ok;
	logic frame_wr;
	logic [6:0] frame_addr;
	logic [31:0] frame_data;
	logic [31:0] rd_word;
	logic [GLOBAL_STATUS_FLAGS_W-1:0] st_set;
	logic [GLOBAL_STATUS_FLAGS_W-1:0] st_clr;
	logic [PERIOD_W:0] hyst;
	logic [PERIOD_W:0] thr_lo;
	logic [PERIOD_W:0] thr_hi;
	logic [PERIOD_W:0] period_ext;

	// Edges seen on the synchronised serial pins
	assign sck_rise = st_r.spi_s.sck & ~st_r.sck_d;
	assign sck_fall = ~st_r.spi_s.sck & st_r.sck_d;
	assign csn_fall = (st_r.spi_state == SPI_IDLE) & ~st_r.spi_s.csn;
	assign csn_rise = (st_r.spi_state == SPI_SHIFT) & st_r.spi_s.csn;

	// Decoded datagram: write flag is the top bit of the address byte, above the seven address bits
	assign frame_ok = csn_rise & (st_r.bit_cnt == FRAME_LEN);
	assign frame_wr = st_r.in_shift[WR_FLAG_POS];
	assign frame_addr = st_r.in_shift[WR_FLAG_POS-1:ADDR_LSB];
	assign frame_data = st_r.in_shift[31:0];

	// Read multiplexer; write-only and unmapped addresses return zero
	always_comb begin
		rd_word = 32'h00000000;
		if (frame_addr == ADDR_GLOBAL_CONFIG_FLAGS) begin
			rd_word[GLOBAL_CONFIG_FLAGS_W-1:0] = st_r.global_config_flags;
		end else if (frame_addr == ADDR_GLOBAL_STATUS_FLAGS) begin
			rd_word[GLOBAL_STATUS_FLAGS_W-1:0] = st_r.global_status_flags;
		end else if (frame_addr == ADDR_INPUT_PINS) begin
			rd_word[IN_PINS_W-1:0] = st_r.pins_s;
			rd_word[IN_FIXED_ONE] = 1'b1;
			rd_word[31:VERSION_LSB] = VERSION_CODE;
		end else if (frame_addr == ADDR_COIL_DIRECT) begin
			rd_word = st_r.coil_current_direct_reg & COIL_CURRENT_DIRECT_REG_MASK;
		end
	end

	// Status set and clear masks; a set in the clear cycle wins
	always_comb begin
		st_set = '0;
		st_set[ST_DRV_ERR] = overtemp_shutdown | short_shutdown;
		st_set[ST_PUMP_UV] = st_r.uv_s;
		st_clr = '0;
		if (frame_ok && frame_wr && frame_addr == ADDR_GLOBAL_STATUS_FLAGS) begin
			st_clr = frame_data[GLOBAL_STATUS_FLAGS_W-1:0];
		end
		if (temp_above_limit) begin
			st_clr[ST_DRV_ERR] = 1'b0;
		end
	end

	// Hysteresis band around the threshold, 1/16 or 1/32 of it
	always_comb begin
		period_ext = {1'b0, step_period};
		if (st_r.global_config_flags[CFG_SMALL_HYST]) begin
			hyst = {1'b0, period_threshold >> HYST_SHIFT_NARROW};
		end else begin
			hyst = {1'b0, period_threshold >> HYST_SHIFT_WIDE};
		end
		thr_lo = {1'b0, period_threshold} - hyst;
		thr_hi = {1'b0, period_threshold} + hyst;
	end

	// Next-state logic for the whole bank
	always_comb begin
		st_nxt = st_r;
		st_nxt.otp_stb = 1'b0;

		// Two-stage synchronisers for every pin input
		st_nxt.spi_m = '{sck: sck, csn: csn, sdi: sdi};
		st_nxt.spi_s = st_r.spi_m;
		st_nxt.sck_d = st_r.spi_s.sck;
		st_nxt.pins_m = '{diag_output_pin: diag_output_pin_i,
			driver_disable_pin: driver_disable_pin,
			speed_mode_input_pin: speed_mode_input_pin,
			speed_mode_enable_pin: speed_mode_enable_pin,
			dir: dir, step: step};
		st_nxt.pins_s = st_r.pins_m;
		st_nxt.uv_m = pump_undervolt_pin;
		st_nxt.uv_s = st_r.uv_m;

		// Serial frame engine: sample on rising, shift out on falling
		case (st_r.spi_state)
			SPI_IDLE: begin
				if (csn_fall) begin
					st_nxt.spi_state = SPI_SHIFT;
					st_nxt.bit_cnt = '0;
					st_nxt.out_shift = {5'h00, st_r.global_status_flags, st_r.rdata};
				end
			end
			SPI_SHIFT: begin
				if (csn_rise) begin
					st_nxt.spi_state = SPI_IDLE;
				end else begin
					if (sck_rise) begin
						st_nxt.in_shift = {st_r.in_shift[FRAME_BITS-2:0],
							st_r.spi_s.sdi};
						if (st_r.bit_cnt != CNT_MAX) begin
							st_nxt.bit_cnt = st_r.bit_cnt + 6'h01;
						end
					end
					if (sck_fall && st_r.bit_cnt != 6'h00) begin
						st_nxt.out_shift = {st_r.out_shift[FRAME_BITS-2:0],
							1'b0};
					end
				end
			end
			default: begin
				st_nxt.spi_state = SPI_IDLE;
			end
		endcase

		// Commit a complete datagram; reads answer in the next frame
		if (frame_ok) begin
			if (frame_wr) begin
				if (frame_addr == ADDR_GLOBAL_CONFIG_FLAGS) begin
					st_nxt.global_config_flags = frame_data[GLOBAL_CONFIG_FLAGS_W-1:0];
				end else if (frame_addr == ADDR_OTP_PROGRAM_TRIGGER) begin
					st_nxt.otp_stb = 1'b1;
					st_nxt.otp_data = frame_data[OTP_W-1:0];
				end else if (frame_addr == ADDR_COIL_DIRECT) begin
					st_nxt.coil_current_direct_reg = frame_data & COIL_CURRENT_DIRECT_REG_MASK;
				end
			end else begin
				st_nxt.rdata = rd_word;
			end
		end

		// Sticky status flags
		st_nxt.global_status_flags = (st_r.global_status_flags & ~st_clr) | st_set;

		// Coil current source select
		if (st_r.global_config_flags[CFG_DIRECT]) begin
			st_nxt.coil_a = st_r.coil_current_direct_reg[COIL_A_LSB +: COIL_W];
			st_nxt.coil_b = st_r.coil_current_direct_reg[COIL_B_LSB +: COIL_W];
		end else begin
			st_nxt.coil_a = seq_coil_a;
			st_nxt.coil_b = seq_coil_b;
		end

		// Comparator keeps its state inside the band
		if (period_ext < thr_lo) begin
			st_nxt.fast = 1'b1;
		end else if (period_ext > thr_hi) begin
			st_nxt.fast = 1'b0;
		end

		// Emergency stop from the halt pin
		st_nxt.halt = st_r.global_config_flags[CFG_STOP_EN]
			& st_r.pins_s.speed_mode_input_pin;

		// Power stage off on undervoltage, latched fault or disable pin
		st_nxt.drv_enable = ~st_r.uv_s & ~st_r.global_status_flags[ST_DRV_ERR]
			& ~st_r.pins_s.driver_disable_pin;
	end

	// State register; reset sets the reset flag and idle-high sck, csn and sck_d in the synchronisers, clears the rest
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.spi_state <= SPI_IDLE;
			st_r.spi_m <= 3'h6;
			st_r.spi_s <= 3'h6;
			st_r.sck_d <= 1'b1;
			st_r.global_config_flags <= GLOBAL_CONFIG_FLAGS_RST;
			st_r.global_status_flags <= GLOBAL_STATUS_FLAGS_RST;
			st_r.coil_current_direct_reg <= COIL_CURRENT_DIRECT_REG_RST;
			st_r.otp_data <= OTP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Serial output drives only inside a frame
	assign sdo_o = st_r.out_shift[FRAME_BITS-1];
	assign sdo_oe = (st_r.spi_state == SPI_SHIFT);

	// Analog test on the diagnostic pin; host keeps it off normally
	assign analog_test_en = st_r.global_config_flags[CFG_TEST];
	assign analog_test_sel = standstill_current_level[1:0];
	assign diag_output_pin_o = 1'b0;
	assign diag_output_pin_oe = st_r.global_config_flags[CFG_TEST];

	// Direct mode side effects on current scaling and regulation
	assign direct_mode_active = st_r.global_config_flags[CFG_DIRECT];
	assign scale_by_standstill = st_r.global_config_flags[CFG_DIRECT];
	assign velocity_reg_disable = st_r.global_config_flags[CFG_DIRECT];

	// Registered outputs to the motor core
	assign coil_a_current = st_r.coil_a;
	assign coil_b_current = st_r.coil_b;
	assign step_faster_than_thr = st_r.fast;
	assign sequencer_halt = st_r.halt;
	assign driver_enable = st_r.drv_enable;
	assign otp_program_trigger_stb = st_r.otp_stb;
	assign otp_program_trigger_data = st_r.otp_data;

endmodule

// >>> tb/mdgcs_chk.sv
// Port assertions for the configuration and status bank
`timescale 1ns/100ps
module mdgcs_chk import mdgcs_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Inputs of the bank
	input wire logic speed_mode_input_pin,
	input wire logic pump_undervolt_pin,
	input wire logic overtemp_shutdown,
	input wire logic short_shutdown,
	input wire logic [COIL_W-1:0] seq_coil_a,
	input wire logic [COIL_W-1:0] seq_coil_b,
	input wire logic [PERIOD_W-1:0] step_period,
	input wire logic [PERIOD_W-1:0] period_threshold,
	// Outputs of the bank
	input wire logic direct_mode_active,
	input wire logic scale_by_standstill,
	input wire logic velocity_reg_disable,
	input wire logic [COIL_W-1:0] coil_a_current,
	input wire logic [COIL_W-1:0] coil_b_current,
	input wire logic analog_test_en,
	input wire logic diag_output_pin_o,
	input wire logic diag_output_pin_oe,
	input wire logic sequencer_halt,
	input wire logic driver_enable,
	input wire logic step_faster_than_thr,
	input wire logic otp_program_trigger_stb
);
	logic [2:0] up_cnt_r;

	// Edges since reset release, so synchroniser history is trusted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			up_cnt_r <= 3'h0;
		end else if (up_cnt_r != 3'h7) begin
			up_cnt_r <= up_cnt_r + 3'h1;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Direct mode flags move together
	chk_mode_mirror:
	assert property (direct_mode_active == scale_by_standstill &&
		direct_mode_active == velocity_reg_disable) else $error("mode flags");
	chk_coil_seq:
	assert property (up_cnt_r == 3'h7 && !$past(direct_mode_active) |->
		coil_a_current == $past(seq_coil_a) &&
		coil_b_current == $past(seq_coil_b)) else $error("coil source");
	chk_test_drive:
	assert property (diag_output_pin_oe == analog_test_en &&
		!diag_output_pin_o) else $error("test drive");
	chk_halt_pin:
	assert property (up_cnt_r == 3'h7 && sequencer_halt |->
		$past(speed_mode_input_pin, 3)) else $error("halt cause");
	chk_uv_off:
	assert property (up_cnt_r == 3'h7 && driver_enable |->
		!$past(pump_undervolt_pin, 3)) else $error("uv enable");
	chk_shut_off:
	assert property (overtemp_shutdown || short_shutdown |-> ##3
		!driver_enable) else $error("shutdown enable");
	chk_hyst_cause:
	assert property ($rose(step_faster_than_thr) |->
		$past(step_period) < $past(period_threshold)) else $error("hyst");
	chk_otp_pulse:
	assert property (otp_program_trigger_stb |=> !otp_program_trigger_stb) else $error("otp pulse");

	// Main scenarios reached
	cov_direct: cover property ($rose(direct_mode_active));
	cov_halt: cover property ($rose(sequencer_halt));
	cov_otp: cover property (otp_program_trigger_stb);
endmodule

// >>> tb/mdgcs_host.sv
// Host model driving the serial register port
`timescale 1ns/100ps
module mdgcs_host (
	// Clock
	input wire logic mclk,
	// Serial pins
	output logic sck,
	output logic csn,
	output logic sdi,
	input wire logic sdo
);
	// Idle levels: clock high, deselected
	initial begin
		sck = 1'b1;
		csn = 1'b1;
		sdi = 1'b0;
	end

	// One 40 bit frame, five mclk per clock phase
	task automatic xfer(input logic w, input logic [6:0] a,
		input logic [31:0] d, output logic [39:0] rx);
		logic [39:0] tx;
		tx = {w, a, d};
		@(negedge mclk);
		csn = 1'b0;
		for (int i = 39; i >= 0; i--) begin
			repeat (5) @(negedge mclk);
			sck = 1'b0;
			sdi = tx[i];
			repeat (5) @(negedge mclk);
			sck = 1'b1;
			rx[i] = sdo;
		end
		repeat (5) @(negedge mclk);
		csn = 1'b1;
		sdi = ~sdi;
		repeat (8) @(negedge mclk);
	endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the configuration and status bank
`timescale 1ns/100ps
module tb import mdgcs_pkg::*;;
	localparam logic [7:0] VER = 8'hA3; // Arbitrary version value
	logic mclk = 1'b0, rst_n = 1'b0, step = 1'b0, dir = 1'b0;
	logic speed_mode_enable_pin = 1'b0, speed_mode_input_pin = 1'b0;
	logic driver_disable_pin = 1'b0, diag_drv = 1'b0;
	logic pump_undervolt_pin = 1'b0, overtemp_shutdown = 1'b0;
	logic short_shutdown = 1'b0, temp_above_limit = 1'b0;
	logic [4:0] standstill_current_level = 5'h00;
	logic [8:0] seq_coil_a = 9'h055, seq_coil_b = 9'h0AA;
	logic [19:0] step_period = 20'h003D0, period_threshold = 20'h00400;
	logic sck, csn, sdi, sdo_o, sdo_oe, dg_o, dg_oe, test_en;
	logic [1:0] test_sel;
	logic fast, halt, direct, scale, vel, drv_en, stb;
	logic [8:0] coil_a, coil_b;
	logic [15:0] otp_data;
	logic [39:0] rx;
	int num_errors = 0, cmp_count = 0, otp_cnt = 0;
	wire sdo_w = sdo_oe ? sdo_o : 1'bz;
	wire diag_w = dg_oe ? dg_o : diag_drv;

	// Clock, pulse counter and watchdog
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (stb === 1'b1) otp_cnt++;
	initial begin
		#1ms;
		num_errors++;
		stop_test();
	end

	// Bank and host
	mdgcs_top #(.VERSION_CODE(VER)) i_mdgcs_top (.mclk(mclk), .rst_n(rst_n),
		.sck(sck), .csn(csn), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.step(step), .dir(dir), .speed_mode_enable_pin(speed_mode_enable_pin),
		.speed_mode_input_pin(speed_mode_input_pin),
		.driver_disable_pin(driver_disable_pin), .diag_output_pin_i(diag_w),
		.diag_output_pin_o(dg_o), .diag_output_pin_oe(dg_oe),
		.analog_test_en(test_en), .analog_test_sel(test_sel),
		.pump_undervolt_pin(pump_undervolt_pin),
		.overtemp_shutdown(overtemp_shutdown), .short_shutdown(short_shutdown),
		.temp_above_limit(temp_above_limit),
		.standstill_current_level(standstill_current_level),
		.seq_coil_a(seq_coil_a), .seq_coil_b(seq_coil_b),
		.step_period(step_period), .period_threshold(period_threshold),
		.step_faster_than_thr(fast), .sequencer_halt(halt),
		.direct_mode_active(direct), .scale_by_standstill(scale),
		.velocity_reg_disable(vel), .coil_a_current(coil_a),
		.coil_b_current(coil_b), .driver_enable(drv_en),
		.otp_program_trigger_stb(stb), .otp_program_trigger_data(otp_data));
	mdgcs_host i_mdgcs_host (.mclk(mclk), .sck(sck), .csn(csn), .sdi(sdi),
		.sdo(sdo_w));

	// Comparisons, waits and register access
	task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		cmp({39'h0, got}, {39'h0, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		i_mdgcs_host.xfer(1'b1, a, d, rx);
		cyc(3);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [39:0] exp);
		i_mdgcs_host.xfer(1'b0, a, 32'h0, rx);
		i_mdgcs_host.xfer(1'b0, ADDR_GLOBAL_CONFIG_FLAGS, 32'h0, rx);
		cmp(rx, exp);
	endtask

	// Status flags: reset, write one to clear, shutdown and undervoltage
	task automatic t_status;
		rdc(ADDR_COIL_DIRECT, 40'h0100000000);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h0);
		rdc(ADDR_GLOBAL_STATUS_FLAGS, 40'h0100000001);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h1);
		rdc(ADDR_GLOBAL_STATUS_FLAGS, 40'h0);
		temp_above_limit = 1'b1;
		overtemp_shutdown = 1'b1;
		cyc(1);
		overtemp_shutdown = 1'b0;
		cyc(3);
		cmp1(drv_en, 1'b0);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
		rdc(ADDR_GLOBAL_STATUS_FLAGS, 40'h0200000002);
		temp_above_limit = 1'b0;
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
		short_shutdown = 1'b1;
		cyc(1);
		short_shutdown = 1'b0;
		rdc(ADDR_GLOBAL_STATUS_FLAGS, 40'h0200000002);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
		cmp1(drv_en, 1'b1);
		pump_undervolt_pin = 1'b1;
		cyc(6);
		cmp1(drv_en, 1'b0);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h4);
		pump_undervolt_pin = 1'b0;
		rdc(ADDR_GLOBAL_STATUS_FLAGS, 40'h0400000004);
		wr(ADDR_GLOBAL_STATUS_FLAGS, 32'h4);
	endtask

	// Pin snapshot in two patterns, write to it ignored
	task automatic t_pins;
		{driver_disable_pin, speed_mode_enable_pin, step} = 3'h7;
		wr(ADDR_INPUT_PINS, 32'hFFFFFFFF);
		rdc(ADDR_INPUT_PINS, {8'h00, VER, 24'h000055});
		{driver_disable_pin, speed_mode_enable_pin, step} = 3'h0;
		{diag_drv, speed_mode_input_pin, dir} = 3'h7;
		rdc(ADDR_INPUT_PINS, {8'h00, VER, 24'h00006A});
		{diag_drv, speed_mode_input_pin, dir} = 3'h0;
	endtask

	// Direct coil mode, test output, halt, hysteresis
	task automatic t_modes;
		wr(ADDR_COIL_DIRECT, 32'hFFFFFFFF);
		rdc(ADDR_COIL_DIRECT, 40'h0001FF01FF);
		wr(ADDR_COIL_DIRECT, 32'h01230145);
		wr(ADDR_GLOBAL_CONFIG_FLAGS, 32'h00010000);
		cmp({22'h0, coil_b, coil_a}, {22'h0, 9'h123, 9'h145});
		cmp1(direct, 1'b1);
		cmp1(scale, 1'b1);
		cmp1(vel, 1'b1);
		standstill_current_level = 5'h1E;
		wr(ADDR_GLOBAL_CONFIG_FLAGS, 32'h00020000); // Only for this
		cmp({22'h0, coil_b, coil_a}, {22'h0, 9'h0AA, 9'h055});
		cmp({37'h0, test_en, test_sel}, 40'h6);
		speed_mode_input_pin = 1'b1;
		wr(ADDR_GLOBAL_CONFIG_FLAGS, 32'h00008000);
		cmp1(halt, 1'b1);
		speed_mode_input_pin = 1'b0;
		cyc(5);
		cmp1(halt, 1'b0);
		cmp1(fast, 1'b0);
		wr(ADDR_GLOBAL_CONFIG_FLAGS, 32'h00004000);
		cmp1(fast, 1'b1);
	endtask

	// Programming trigger, then a second reset
	task automatic t_otp_reset;
		wr(ADDR_OTP_PROGRAM_TRIGGER, 32'h0000BD12);
		cmp({otp_cnt == 1, 23'h0, otp_data}, 40'h800000BD12);
		rdc(ADDR_OTP_PROGRAM_TRIGGER, 40'h0);
		rst_n = 1'b0;
		cyc(3);
		rst_n = 1'b1;
		cyc(4);
		rdc(ADDR_GLOBAL_CONFIG_FLAGS, 40'h0100000000);
	endtask

	task automatic stop_test;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Reset, then scenarios
	initial begin
		cyc(10);
		rst_n = 1'b1;
		cyc(4);
		t_status();
		t_pins();
		t_modes();
		t_otp_reset();
		stop_test();
	end
endmodule

bind mdgcs_top mdgcs_chk i_mdgcs_chk (.mclk(mclk), .rst_n(rst_n),
	.speed_mode_input_pin(speed_mode_input_pin),
	.pump_undervolt_pin(pump_undervolt_pin),
	.overtemp_shutdown(overtemp_shutdown), .short_shutdown(short_shutdown),
	.seq_coil_a(seq_coil_a), .seq_coil_b(seq_coil_b),
	.step_period(step_period), .period_threshold(period_threshold),
	.direct_mode_active(direct_mode_active),
	.scale_by_standstill(scale_by_standstill),
	.velocity_reg_disable(velocity_reg_disable),
	.coil_a_current(coil_a_current), .coil_b_current(coil_b_current),
	.analog_test_en(analog_test_en), .diag_output_pin_o(diag_output_pin_o),
	.diag_output_pin_oe(diag_output_pin_oe), .sequencer_halt(sequencer_halt),
	.driver_enable(driver_enable), .otp_program_trigger_stb(otp_program_trigger_stb),
	.step_faster_than_thr(step_faster_than_thr));
